/* ccrd_decode.sv */
// card configuration register bank with attribute and common decode
//
// How it works
// - config registers sit at attribute base 200h
// - offset 200h reads and writes option register
// - offset 202h selects config and status register
// - offset 204h selects pin replacement register
// - both enables high means standby, nothing decoded
// - even enable alone: common byte on low lanes
// - odd enable alone: common byte on high lanes
// - both enables, A0 low: common 16-bit word
// - writes to information structure are invalid, ignored
// - odd attribute address or odd enable alone: invalid
// - soft reset bit holds card in reset
// - soft reset bit cleared by hardware reset
// - bit 6 selects level or pulse interrupts
// - six-bit index picks mode; 1 is contiguous
// - index 0: memory map, task file mirrored
// - index 2: primary I/O task file map
// - index 3: secondary I/O task file map
// - option register all eight bits, reset zero
// - status registers return the user-side bytes in every mode
`default_nettype none
`include "ccrd_regs.svh"

module ccrd_decode (
    input  wire logic                    clk_sys,           // 10 MHz clock
    input  wire logic                    rst_b,             // hw reset, low
    input  wire logic                    high_byte_enable_n,// odd lane en
    input  wire logic                    low_byte_enable_n, // even lane en
    input  wire logic                    reg_sel_n,         // attribute sel
    input  wire logic                    out_en_n,          // read strobe
    input  wire logic                    wr_en_n,           // write strobe
    input  wire logic [10:0]             addr,              // bus address
    input  wire logic [15:0]             data_in,           // bus data in
    output logic      [15:0]             data_out,          // bus data out
    output logic      [1:0]              data_oe,           // lane enables
    input  wire logic [7:0]              info_rdata,        // info byte
    input  wire logic [7:0]              ccsr_rdata,        // status byte
    input  wire logic [7:0]              prr_rdata,         // pin repl byte
    input  wire logic [15:0]             cm_rdata,          // common data
    output logic                         ccsr_wr,           // status write
    output logic                         prr_wr,            // pin repl wr
    output logic      [7:0]              cfg_wdata,         // reg wr byte
    output logic                         cm_rd,             // common read
    output logic                         cm_wr,             // common write
    output logic      [1:0]              cm_lanes,          // lanes in use
    output logic      [10:0]             cm_addr,           // common addr
    output logic      [15:0]             cm_wdata,          // common wdata
    output logic                         invalid_access,    // bad access
    output logic                         card_reset,        // soft reset
    output logic                         irq_level_mode,    // 1 = level
    output logic      [5:0]              config_index,      // mode index
    output ccrd_pkg::ccrd_map_t          map_mode,          // mapping mode
    output logic                         tf_hit,            // task file hit
    output logic      [3:0]              tf_index           // task file reg
);
    import ccrd_pkg::*;

    // decode one bus sample into the space it selects
    function automatic ccrd_acc_t acc_decode(input ccrd_pins_t b);
        ccrd_acc_t a;
        a = ACC_NONE;
        if (b.high_byte_enable_n && b.low_byte_enable_n) begin
            a = ACC_NONE;
        end else if (!b.reg_sel_n) begin
            // attribute space: even bytes under the low enable only
            if (b.low_byte_enable_n || b.addr[0]) begin
                a = ACC_INVALID;
            end else if (b.addr == `CCRD_COR_OFS) begin
                a = ACC_COR;
            end else if (b.addr == `CCRD_CCSR_OFS) begin
                a = ACC_CCSR;
            end else if (b.addr == `CCRD_PRR_OFS) begin
                a = ACC_PRR;
            end else if (!b.addr[10] && !b.addr[9]) begin
                // the structure is read only
                a = b.wr_en_n ? ACC_INFO : ACC_INVALID;
            end else begin
                a = ACC_RESV;
            end
        end else if (b.high_byte_enable_n) begin
            a = ACC_CM_LO;
        end else if (b.low_byte_enable_n) begin
            a = ACC_CM_HI;
        end else if (!b.addr[0]) begin
            a = ACC_CM_WORD;
        end
        return a;
    endfunction : acc_decode

    // lanes driven for a common memory access
    function automatic logic [1:0] cm_lane_mask(input ccrd_acc_t a);
        logic [1:0] m;
        m = 2'h0;
        if (a == ACC_CM_LO) begin
            m = 2'h1;
        end else if (a == ACC_CM_HI) begin
            m = 2'h2;
        end else if (a == ACC_CM_WORD) begin
            m = 2'h3;
        end
        return m;
    endfunction : cm_lane_mask

    ccrd_pins_t pins_now;    // raw pins, asynchronous to clk_sys
    ccrd_pins_t sync1_r;     // first synchroniser stage
    ccrd_pins_t bus_r;       // second stage, safe to decode
    ccrd_pins_t cap_r;       // bus held while write strobe low
    logic       wr_prev_r;   // last synced write strobe
    logic       rd_prev_r;   // last synced read active
    logic [7:0] cor_r;       // config option register
    logic [7:0] cor_nxt;     // its next value on a write
    logic [15:0] rdata_r;    // read data driven to lanes
    logic [1:0] oe_r;        // lane drive enables
    logic       ccsr_wr_r;   // status write pulse
    logic       prr_wr_r;    // pin replacement write pulse
    logic [7:0] cfg_wdata_r; // byte written to a register
    logic       cm_wr_r;     // common write pulse
    logic [1:0] lanes_r;     // common lanes of last access
    logic [10:0] cm_addr_r;  // common address
    logic [15:0] cm_wdata_r; // common write data
    logic       invalid_r;   // invalid access pulse
    logic       tf_hit_r;    // task file decode hit
    logic [3:0] tf_index_r;  // task file register index

    // decode wires
    ccrd_acc_t  live_acc;    // access of the current bus sample
    ccrd_acc_t  wr_acc;      // access of the captured write
    logic       rd_act;      // read strobe alone is active
    logic       commit;      // write strobe released this cycle
    logic [15:0] rd_sel;     // read data chosen from live access
    logic [1:0] rd_lanes;    // lanes that read drives
    logic       tf_match;    // address in the current task file
    logic [3:0] tf_sel;      // task file register index chosen
    logic [9:0] io_a;        // low ten address bits for I/O maps

    assign pins_now = '{high_byte_enable_n, low_byte_enable_n, reg_sel_n,
                        out_en_n, wr_en_n, addr, data_in};

    assign live_acc = acc_decode(bus_r);
    assign wr_acc   = acc_decode(cap_r);
    assign rd_act   = !bus_r.out_en_n && bus_r.wr_en_n;
    // release edge gives one commit per write cycle
    assign commit   = bus_r.wr_en_n && !wr_prev_r;

    // bring every pin through two flops before decoding
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sync1_r <= ccrd_pins_t'(`CCRD_PINS_IDLE);
            bus_r   <= ccrd_pins_t'(`CCRD_PINS_IDLE);
        end else begin
            sync1_r <= pins_now;
            bus_r   <= sync1_r;
        end
    end

    // hold address and data while the write strobe is low, so a host
    // that moves the address right after release still writes correctly
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cap_r     <= ccrd_pins_t'(`CCRD_PINS_IDLE);
            wr_prev_r <= 1'b1;
            rd_prev_r <= 1'b0;
        end else begin
            if (!bus_r.wr_en_n) begin
                cap_r <= bus_r;
            end
            wr_prev_r <= bus_r.wr_en_n;
            rd_prev_r <= rd_act;
        end
    end

    // option register write: soft reset clears the other fields, and
    // leaving soft reset returns to the unconfigured power-up state
    assign cor_nxt = cor_r[`CCRD_COR_SOFT_RST] ?
                     (cap_r.data[`CCRD_COR_SOFT_RST] ? `CCRD_COR_SOFT_ONLY
                                                     : `CCRD_COR_RST)
                   : (cap_r.data[`CCRD_COR_SOFT_RST] ? `CCRD_COR_SOFT_ONLY
                                                     : cap_r.data[7:0]);

    // config option register, cleared by hardware reset
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cor_r <= `CCRD_COR_RST;
        end else if (commit && wr_acc == ACC_COR) begin
            cor_r <= cor_nxt;
        end
    end

    assign card_reset     = cor_r[`CCRD_COR_SOFT_RST];
    assign irq_level_mode = cor_r[`CCRD_COR_IRQ_LVL];
    assign config_index   = cor_r[`CCRD_COR_IDX_MSB:0];

    // mapping mode from the index; other codes map nothing
    assign map_mode = (config_index == `CCRD_IDX_MEMORY)   ? MAP_MEMORY
                    : (config_index == `CCRD_IDX_CONTIG)   ? MAP_CONTIG
                    : (config_index == `CCRD_IDX_PRIMARY)  ? MAP_PRIMARY
                    : (config_index == `CCRD_IDX_SECONDARY)? MAP_SECONDARY
                    : MAP_UNDEF;

    // task file windows; I/O maps look at the address only, the user
    // side qualifies them with its own I/O strobes
    assign io_a = bus_r.addr[9:0];
    assign tf_match =
        (map_mode == MAP_MEMORY &&
         (bus_r.addr[10:4] == 7'h00 ||
          bus_r.addr[10] == 1'(`CCRD_MEM_MIRROR >> 10)))
      || (map_mode == MAP_CONTIG)
      || (map_mode == MAP_PRIMARY &&
          (io_a[9:3] == 7'(`CCRD_PRI_TF >> 3) ||
           io_a[9:1] == 9'(`CCRD_PRI_ALT >> 1)))
      || (map_mode == MAP_SECONDARY &&
          (io_a[9:3] == 7'(`CCRD_SEC_TF >> 3) ||
           io_a[9:1] == 9'(`CCRD_SEC_ALT >> 1)));
    assign tf_sel =
        ((map_mode == MAP_PRIMARY && io_a[9:1] == 9'(`CCRD_PRI_ALT >> 1)) ||
         (map_mode == MAP_SECONDARY && io_a[9:1] == 9'(`CCRD_SEC_ALT >> 1)))
        ? (`CCRD_ALT_BASE_IDX | {3'h0, io_a[0]})
        : ((map_mode == MAP_PRIMARY || map_mode == MAP_SECONDARY)
           ? {1'b0, io_a[2:0]} : bus_r.addr[3:0]);

    // task file hit only while a card enable is low
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tf_hit_r   <= 1'b0;
            tf_index_r <= 4'h0;
        end else begin
            tf_hit_r   <= tf_match && live_acc != ACC_NONE &&
                          bus_r.reg_sel_n;
            tf_index_r <= tf_sel;
        end
    end

    // read data by access; status registers return the user-side bytes in every mode
    assign rd_sel = (live_acc == ACC_COR)  ? {8'h00, cor_r}
                  : (live_acc == ACC_CCSR) ? {8'h00, ccsr_rdata}
                  : (live_acc == ACC_PRR)  ? {8'h00, prr_rdata}
                  : (live_acc == ACC_INFO) ? {8'h00, info_rdata}
                  : (live_acc == ACC_RESV) ? `CCRD_DATA_ZERO
                  : cm_rdata;
    // attribute reads drive the even byte; invalid reads drive nothing
    assign rd_lanes = (live_acc == ACC_COR || live_acc == ACC_CCSR ||
                       live_acc == ACC_PRR || live_acc == ACC_INFO ||
                       live_acc == ACC_RESV) ? 2'h1
                    : cm_lane_mask(live_acc);

    // read path, registered so the lanes never glitch
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= `CCRD_DATA_ZERO;
            oe_r    <= 2'h0;
        end else if (rd_act) begin
            rdata_r <= rd_sel;
            oe_r    <= rd_lanes;
        end else begin
            oe_r    <= 2'h0;
        end
    end

    // write side pulses, one cycle after the strobe release is seen
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ccsr_wr_r   <= 1'b0;
            prr_wr_r    <= 1'b0;
            cfg_wdata_r <= 8'h00;
            cm_wr_r     <= 1'b0;
            cm_wdata_r  <= `CCRD_DATA_ZERO;
        end else begin
            ccsr_wr_r <= commit && wr_acc == ACC_CCSR;
            prr_wr_r  <= commit && wr_acc == ACC_PRR;
            cm_wr_r   <= commit && cm_lane_mask(wr_acc) != 2'h0;
            if (commit) begin
                cfg_wdata_r <= cap_r.data[7:0];
                cm_wdata_r  <= cap_r.data;
            end
        end
    end

    // common memory lanes and address follow the current access
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            lanes_r   <= 2'h0;
            cm_addr_r <= 11'h000;
        end else if (commit) begin
            lanes_r   <= cm_lane_mask(wr_acc);
            cm_addr_r <= cap_r.addr;
        end else if (rd_act) begin
            lanes_r   <= cm_lane_mask(live_acc);
            cm_addr_r <= bus_r.addr;
        end
    end

    // invalid access flagged at read start or write release; the
    // write itself changes nothing
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            invalid_r <= 1'b0;
        end else begin
            invalid_r <= (commit && wr_acc == ACC_INVALID) ||
                         (rd_act && !rd_prev_r &&
                          live_acc == ACC_INVALID);
        end
    end

    assign data_out       = rdata_r;
    assign data_oe        = oe_r;
    assign ccsr_wr        = ccsr_wr_r;
    assign prr_wr         = prr_wr_r;
    assign cfg_wdata      = cfg_wdata_r;
    assign cm_rd          = rd_act && cm_lane_mask(live_acc) != 2'h0;
    assign cm_wr          = cm_wr_r;
    assign cm_lanes       = lanes_r;
    assign cm_addr        = cm_addr_r;
    assign cm_wdata       = cm_wdata_r;
    assign invalid_access = invalid_r;
    assign tf_hit         = tf_hit_r;
    assign tf_index       = tf_index_r;

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_commit(ccrd_acc_t k);
        commit && wr_acc == k;
    endsequence

    sequence s_cor_read;
        rd_act && live_acc == ACC_COR;
    endsequence

    a_standby_no_drive: assert property (
        live_acc == ACC_NONE |=> oe_r == 2'h0)
        else $error("lanes driven after standby sample");
    a_cor_write_takes: assert property (
        s_commit(ACC_COR) |=> cor_r == $past(cor_nxt))
        else $error("option register missed a write");
    a_soft_reset_clear: assert property (
        $rose(card_reset) |-> config_index == 6'h00 && !irq_level_mode)
        else $error("soft reset left fields set");
    a_ccsr_pulse: assert property (
        s_commit(ACC_CCSR) |=> ccsr_wr ##1 !ccsr_wr)
        else $error("status write pulse wrong");
    a_prr_pulse: assert property (
        s_commit(ACC_PRR) |=> prr_wr && cfg_wdata == $past(cap_r.data[7:0]))
        else $error("pin replacement write wrong");
    a_invalid_no_effect: assert property (
        s_commit(ACC_INVALID) |=> $stable(cor_r) && !cm_wr && invalid_access)
        else $error("invalid write had an effect");
    a_write_once: assert property (
        cm_wr |=> !cm_wr)
        else $error("common write committed twice");
    a_word_lanes: assert property (
        s_commit(ACC_CM_WORD) |=> cm_wr && cm_lanes == 2'h3)
        else $error("word write lanes wrong");
    a_memory_map: assert property (
        config_index == 6'h00 |-> map_mode == MAP_MEMORY)
        else $error("index zero not memory map");
    a_cor_readback: assert property (
        s_cor_read |=> data_out[7:0] == $past(cor_r) && data_oe == 2'h1)
        else $error("option register read wrong");

endmodule : ccrd_decode

`default_nettype wire

/* ccrd_regs.svh */
// offsets, field positions, reset values and mapping constants
`ifndef CCRD_REGS_SVH
`define CCRD_REGS_SVH

// attribute-space register offsets (byte addresses, even only)
`define CCRD_COR_OFS        11'h200
`define CCRD_CCSR_OFS       11'h202
`define CCRD_PRR_OFS        11'h204

// config option register fields and reset value
`define CCRD_COR_SOFT_RST   7
`define CCRD_COR_IRQ_LVL    6
`define CCRD_COR_IDX_MSB    5
`define CCRD_COR_RST        8'h00
`define CCRD_COR_SOFT_ONLY  8'h80

// configuration index encodings
`define CCRD_IDX_MEMORY     6'h00
`define CCRD_IDX_CONTIG     6'h01
`define CCRD_IDX_PRIMARY    6'h02
`define CCRD_IDX_SECONDARY  6'h03

// task file windows
`define CCRD_MEM_MIRROR     11'h400
`define CCRD_PRI_TF         10'h1F0
`define CCRD_PRI_ALT        10'h3F6
`define CCRD_SEC_TF         10'h170
`define CCRD_SEC_ALT        10'h376
`define CCRD_ALT_BASE_IDX   4'hE

// idle card bus: every strobe and enable high, address and data zero
`define CCRD_PINS_IDLE      32'hF800_0000
`define CCRD_DATA_ZERO      16'h0000

`endif

/* ccrd_pkg.sv */
// types shared by the card configuration decode block
`default_nettype none

package ccrd_pkg;

    // one sample of the card bus pins, strobes active low
    typedef struct packed {
        logic        high_byte_enable_n; // odd byte lane enable
        logic        low_byte_enable_n;  // even byte lane enable
        logic        reg_sel_n;          // attribute space select
        logic        out_en_n;           // read strobe
        logic        wr_en_n;            // write strobe
        logic [10:0] addr;               // byte address
        logic [15:0] data;               // write data from host
    } ccrd_pins_t;

    // what a bus sample selects
    typedef enum logic [3:0] {
        ACC_NONE,      // standby or nothing decoded
        ACC_COR,       // config option register
        ACC_CCSR,      // config and status register
        ACC_PRR,       // pin replacement register
        ACC_INFO,      // card information structure
        ACC_RESV,      // reserved attribute location
        ACC_INVALID,   // invalid attribute access
        ACC_CM_LO,     // common memory, even byte
        ACC_CM_HI,     // common memory, odd byte
        ACC_CM_WORD    // common memory, 16-bit word
    } ccrd_acc_t;

    // mapping mode chosen by the configuration index
    typedef enum logic [2:0] {
        MAP_MEMORY,
        MAP_CONTIG,
        MAP_PRIMARY,
        MAP_SECONDARY,
        MAP_UNDEF
    } ccrd_map_t;

endpackage : ccrd_pkg

`default_nettype wire

/* ccrd_host_model.sv */
// host controller model driving the card bus pins
`default_nettype none
`include "ccrd_regs.svh"

module ccrd_host_model
    import ccrd_pkg::*;
(
    input  wire logic        clk_sys,  // bench clock
    input  wire logic [15:0] data_out, // card read data
    input  wire logic [1:0]  data_oe,  // card lane drive
    output var ccrd_pkg::ccrd_pins_t pins // card bus pins
);
    timeunit 1ns;
    timeprecision 1ns;
    import ccrd_pkg::*;

    // bus idle from time zero, all strobes and enables high
    initial pins = `CCRD_PINS_IDLE;

    // one cycle: strobe low four clocks so the card syncs it reliably,
    // address held past the write release; the commit uses the copy captured while strobe low
    task automatic cyc(
        input  logic [1:0]  en_n,  // {high, low} byte enables
        input  logic        reg_n, // attribute select
        input  logic        wr,    // 1 write, 0 read
        input  logic [10:0] a,     // byte address
        input  logic [15:0] d,     // write data
        output logic [15:0] rd,    // data seen at end of strobe
        output logic [1:0]  oe     // lanes seen at end of strobe
    );
        @(negedge clk_sys);
        pins <= '{en_n[1], en_n[0], reg_n, wr, !wr, a, d};
        repeat (4) @(negedge clk_sys);
        rd = data_out;
        oe = data_oe;
        pins.out_en_n <= 1'b1;
        pins.wr_en_n  <= 1'b1;
        repeat (4) @(negedge clk_sys);
        // enables dropped between cycles, data lines no longer valid
        pins <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 11'h000, ~d};
        repeat (4) @(negedge clk_sys);
    endtask : cyc
endmodule : ccrd_host_model

`default_nettype wire

/* tb_top.sv */
// self-checking bench for the card configuration decode block
`default_nettype none
`include "ccrd_regs.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import ccrd_pkg::*;

    logic        clk_sys = 1'b0;            // 100 ns clock
    logic        rst_b   = 1'b0;            // hardware reset
    ccrd_pins_t  pins;                      // host-driven pins
    logic [15:0] data_out, cm_wdata, rd, m; // read data, masks
    logic [1:0]  data_oe, cm_lanes, oe;     // lane enables
    logic        ccsr_wr, prr_wr, cm_wr, invalid_access, cm_rd;
    logic        card_reset, irq_level_mode, tf_hit;
    logic [7:0]  cfg_wdata;                 // committed register byte
    logic [10:0] cm_addr;                   // last access address
    logic [5:0]  config_index;              // mode index
    logic [3:0]  tf_index;                  // task file register
    ccrd_map_t   map_mode;                  // decoded mapping
    logic [7:0]  info_rdata = 8'h9D;        // user-side bytes
    logic [7:0]  ccsr_rdata = 8'h3C;
    logic [7:0]  prr_rdata  = 8'hA5;
    logic [15:0] cm_rdata   = 16'h6E21;
    logic [3:0]  seen = 4'h0;               // sticky pulse flags
    logic [5:0]  tfs  = 6'h00;              // common read, hit, index
    int          mismatches = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    // option values and the mapping each one selects
    logic [7:0]  wv [5] = '{8'h41, 8'h02, 8'h03, 8'h80, 8'h00};
    ccrd_map_t   mv [5] = '{MAP_CONTIG, MAP_PRIMARY, MAP_SECONDARY,
                            MAP_MEMORY, MAP_MEMORY};
    // refused accesses: enables, write, address
    logic [1:0]  ie [7] = '{2'b10, 2'b10, 2'b10, 2'b01, 2'b01, 2'b11, 2'b11};
    logic        iw [7] = '{1, 0, 1, 0, 1, 1, 0};
    logic [10:0] ia [7] = '{11'h000, 11'h201, 11'h201, 11'h200, 11'h200,
                            11'h200, 11'h200};
    logic [1:0]  ce [3] = '{2'b10, 2'b01, 2'b00}; // common enables
    // task file windows: option value, common address, expectation
    logic [7:0]  tc [7] = '{8'h00, 8'h41, 8'h02, 8'h02, 8'h03, 8'h03, 8'h05};
    logic [10:0] ta [7] = '{11'h405, 11'h0A4, 11'h1F3, 11'h3F7, 11'h176,
                            11'h376, 11'h1F0};
    logic [5:0]  tx [7] = '{6'h35, 6'h34, 6'h33, 6'h3F, 6'h36, 6'h3E, 6'h20};
    ccrd_map_t   tm [7] = '{MAP_MEMORY, MAP_CONTIG, MAP_PRIMARY, MAP_PRIMARY,
                            MAP_SECONDARY, MAP_SECONDARY, MAP_UNDEF};

    always #50 clk_sys = ~clk_sys;

    // pulses last one cycle, so latch them until the next operation
    always @(posedge clk_sys) seen <= seen | {invalid_access, cm_wr,
                                              prr_wr, ccsr_wr};

    // task file hit and common read strobe, latched per operation too
    always @(posedge clk_sys) begin
        tfs <= tfs | {cm_rd, tf_hit ? {1'b1, tf_index} : 5'h00};
    end

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            end_of_test();
        end
    end

    ccrd_host_model host (.clk_sys, .data_out, .data_oe, .pins);

    ccrd_decode uut (
        .clk_sys, .rst_b, .data_out, .data_oe,
        .high_byte_enable_n(pins.high_byte_enable_n),
        .low_byte_enable_n(pins.low_byte_enable_n),
        .reg_sel_n(pins.reg_sel_n), .out_en_n(pins.out_en_n),
        .wr_en_n(pins.wr_en_n), .addr(pins.addr), .data_in(pins.data),
        .info_rdata, .ccsr_rdata, .prr_rdata, .cm_rdata, .ccsr_wr,
        .prr_wr, .cfg_wdata, .cm_rd, .cm_wr, .cm_lanes, .cm_addr,
        .cm_wdata, .invalid_access, .card_reset, .irq_level_mode,
        .config_index, .map_mode, .tf_hit, .tf_index
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one bus operation with the pulse flags cleared first
    task automatic op(input logic [1:0] en, input logic reg_n,
                      input logic w, input logic [10:0] a,
                      input logic [15:0] d);
        seen <= 4'h0;
        tfs  <= 6'h00;
        host.cyc(en, reg_n, w, a, d, rd, oe);
    endtask : op

    task automatic end_of_test();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (4) @(negedge clk_sys);
        rst_b = 1'b1;
        // host reads the information structure first to find registers
        op(2'b10, 1'b0, 1'b0, 11'h000, 16'h0000);
        chk({rd[7:0], 2'h0, seen, oe}, {info_rdata, 8'h01});
        op(2'b10, 1'b0, 1'b0, 11'h400, 16'h0000);
        chk({rd[7:0], 2'h0, seen, oe}, 16'h0001);
        op(2'b10, 1'b0, 1'b0, `CCRD_COR_OFS, 16'h0000);
        chk({rd[7:0], 6'h00, oe}, 16'h0001);
        // every mode index, level bit and soft reset, then read back
        for (int i = 0; i < 5; i++) begin
            op(2'b10, 1'b0, 1'b1, `CCRD_COR_OFS, {8'h00, wv[i]});
            chk({card_reset, irq_level_mode, config_index, 5'h00, map_mode},
                {wv[i], 5'h00, mv[i]});
            op(2'b10, 1'b0, 1'b0, `CCRD_COR_OFS, 16'h0000);
            chk({rd[7:0], 6'h00, oe}, {wv[i], 8'h01});
        end
        op(2'b10, 1'b0, 1'b1, `CCRD_CCSR_OFS, 16'h0055);
        chk({cfg_wdata, 4'h0, seen}, 16'h5501);
        op(2'b10, 1'b0, 1'b1, `CCRD_PRR_OFS, 16'h00A6);
        chk({cfg_wdata, 4'h0, seen}, 16'hA602);
        op(2'b10, 1'b0, 1'b0, `CCRD_CCSR_OFS, 16'h0000);
        chk({rd[7:0], 6'h00, oe}, {ccsr_rdata, 8'h01});
        op(2'b10, 1'b0, 1'b0, `CCRD_PRR_OFS, 16'h0000);
        chk({rd[7:0], 6'h00, oe}, {prr_rdata, 8'h01});
        // soft reset write keeps only its bit, then a mid-run hardware
        // reset clears it
        op(2'b10, 1'b0, 1'b1, `CCRD_COR_OFS, 16'h00C3);
        chk({card_reset, irq_level_mode, config_index, 5'h00, map_mode},
            {13'h1000, MAP_MEMORY});
        rst_b = 1'b0;
        @(negedge clk_sys);
        rst_b = 1'b1;
        chk({card_reset, irq_level_mode, config_index, 5'h00, map_mode},
            {13'h0000, MAP_MEMORY});
        // refused and standby accesses must leave the register alone
        for (int i = 0; i < 7; i++) begin
            op(ie[i], 1'b0, iw[i], ia[i], 16'hFFFF);
            chk({10'h000, seen, oe},
                (i < 5) ? 16'h0020 : 16'h0000);
        end
        chk({card_reset, irq_level_mode, config_index}, 16'h0000);
        // common memory byte and word lanes, reads and writes
        for (int i = 0; i < 6; i++) begin
            m = {{8{~ce[i / 2][1]}}, {8{~ce[i / 2][0]}}};
            op(ce[i / 2], 1'b1, i[0], 11'h0A4, 16'hC35A);
            chk((i[0] ? cm_wdata : rd) & m,
                (i[0] ? 16'hC35A : cm_rdata) & m);
            chk({i[0] ? cm_lanes : oe, seen, cm_addr[9:0]},
                {~ce[i / 2], i[0] ? 4'h4 : 4'h0, 10'h0A4});
        end
        // task file window and index in each mapping mode, common reads
        for (int i = 0; i < 7; i++) begin
            op(2'b10, 1'b0, 1'b1, `CCRD_COR_OFS, {8'h00, tc[i]});
            op(2'b10, 1'b1, 1'b0, ta[i], 16'h0000);
            chk({2'h0, tfs, 5'h00, map_mode},
                {2'h0, tx[i], 5'h00, tm[i]});
        end
        end_of_test();
    end
endmodule : tb_top

`default_nettype wire
